// ===== sled_params.svh
// Register offsets, field positions, reset values and timing constants of the status lamp sequencer
`ifndef SLED_PARAMS_SVH
`define SLED_PARAMS_SVH

// Clock and pattern timing, times in their own units
`define SLED_CLK_PERIOD_PS 5000
`define SLED_MS_IN_PS 1000000000
`define SLED_CYC_PER_MS (`SLED_MS_IN_PS / `SLED_CLK_PERIOD_PS)
`define SLED_FLICK_MS 50
`define SLED_BLINK_MS 200
`define SLED_DBL_GAP_MS 1000
`define SLED_DBL_CYCLE_MS (3 * `SLED_BLINK_MS + `SLED_DBL_GAP_MS)
`define SLED_PDM_MAX_MS 15

// Register word indices; byte address is four times the index
`define SLED_REG_CTRL 3'h0
`define SLED_REG_STAT 3'h1
`define SLED_REG_IRQ_STAT 3'h2
`define SLED_REG_IRQ_MASK 3'h3
`define SLED_REG_COND 3'h4

// Control register fields
`define SLED_CTRL_EN_BIT 0
`define SLED_CTRL_TEST_BIT 1
`define SLED_CTRL_DLY_LSB 4
`define SLED_CTRL_DLY_MSB 7
`define SLED_CTRL_RESET 32'h0000_00f1

// Event bits of the interrupt status and mask registers
`define SLED_EV_WDOG 0
`define SLED_EV_BUS 1
`define SLED_EV_FIELD 2
`define SLED_EV_NONFATAL 3
`define SLED_EV_FAIL 4
`define SLED_EV_W 5

`endif

// ===== sled_pkg.sv
// Types shared by the status lamp sequencer modules
package sled_pkg;
    typedef enum logic [2:0] {
        SLED_PAT_OFF,
        SLED_PAT_ON,
        SLED_PAT_FLICK,
        SLED_PAT_BLINK1,
        SLED_PAT_BLINK2
    } sled_pat_t;
    typedef logic [3:0] sled_ms_t;
endpackage

// ===== sled_pat_if.sv
// Carrier for the millisecond tick and the free running lamp waveforms
`timescale 1ns/100ps
interface sled_pat_if;
    logic tick_ms;
    logic flick;
    logic blink1;
    logic blink2;
    modport src (output tick_ms, output flick, output blink1, output blink2);
    modport sink (input tick_ms, input flick, input blink1, input blink2);
endinterface

// ===== sled_pattern.sv
// Millisecond timebase and flicker, single blink and double blink waveforms
`timescale 1ns/100ps
`include "sled_params.svh"
module sled_pattern #(
    parameter int CYC_PER_MS = `SLED_CYC_PER_MS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Waveforms out
    sled_pat_if.src pat
);
    import sled_pkg::*;

    logic [31:0] cyc_q;
    logic [15:0] flk_q;
    logic [15:0] blk_q;
    logic [15:0] dbl_q;
    logic flick_q;
    logic blink1_q;
    logic tick_q;
    wire cyc_end = (cyc_q == 32'(CYC_PER_MS - 1));
    wire flk_end = (flk_q == 16'(`SLED_FLICK_MS - 1));
    wire blk_end = (blk_q == 16'(`SLED_BLINK_MS - 1));
    wire dbl_end = (dbl_q == 16'(`SLED_DBL_CYCLE_MS - 1));

    // Cycle divider gives one tick per millisecond
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            cyc_q <= cyc_end ? 32'h0 : cyc_q + 32'h1;
            tick_q <= cyc_end;
        end
    end

    // Flicker: 50 ms lit, 50 ms dark
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flk_q <= 16'h0;
            flick_q <= 1'b1;
        end else if (tick_q) begin
            flk_q <= flk_end ? 16'h0 : flk_q + 16'h1;
            if (flk_end) begin
                flick_q <= ~flick_q;
            end
        end
    end

    // Single blink: 200 ms lit, 200 ms dark
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            blk_q <= 16'h0;
            blink1_q <= 1'b1;
        end else if (tick_q) begin
            blk_q <= blk_end ? 16'h0 : blk_q + 16'h1;
            if (blk_end) begin
                blink1_q <= ~blink1_q;
            end
        end
    end

    // Double blink frame: lit, dark, lit, then a long dark gap
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dbl_q <= 16'h0;
        end else if (tick_q) begin
            dbl_q <= dbl_end ? 16'h0 : dbl_q + 16'h1;
        end
    end

    assign pat.tick_ms = tick_q;
    assign pat.flick = flick_q;
    assign pat.blink1 = blink1_q;
    assign pat.blink2 = (dbl_q < 16'(`SLED_BLINK_MS)) ||
        ((dbl_q >= 16'(2 * `SLED_BLINK_MS)) && (dbl_q < 16'(3 * `SLED_BLINK_MS)));
endmodule

// ===== sled_qual.sv
// Qualifies a remote fault for a programmable number of milliseconds
`timescale 1ns/100ps
`include "sled_params.svh"
module sled_qual (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Timebase and setting
    input wire logic tick_ms,
    input wire sled_pkg::sled_ms_t delay_ms,
    // Fault in and qualified out
    input wire logic raw,
    output logic qual
);
    import sled_pkg::*;

    sled_ms_t cnt_q;
    logic qual_q;
    // Setting is a 4-bit field so the wait never passes 15 ms
    wire done = (cnt_q >= delay_ms);

    // Fault must stand the delay; it clears at once
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            qual_q <= 1'b0;
        end else if (!raw) begin
            cnt_q <= 4'h0;
            qual_q <= 1'b0;
        end else begin
            qual_q <= done;
            if (tick_ms && !done) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    // Gated by the raw input so the qualified fault drops in the same cycle as its cause
    assign qual = qual_q && raw;
endmodule

// ===== sled_top.sv
// Status lamp sequencer: condition flags to ready and fault lamp patterns, with register slave
`timescale 1ns/100ps
`include "sled_params.svh"

module sled_top #(
    parameter int CYC_PER_MS = `SLED_CYC_PER_MS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Module condition flags
    input wire logic logic_pwr_ok,
    input wire logic mod_failed,
    input wire logic auto_addr,
    input wire logic wdog_timeout,
    input wire logic operational,
    input wire logic pre_op,
    input wire logic field_pwr_lost,
    input wire logic power_distribution_module_short,
    input wire logic nonfatal_err,
    input wire logic island_bus_stopped,
    // Lamps
    output logic ready_led,
    output logic fault_led,
    // Avalon-MM slave
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq
);
    import sled_pkg::*;

    sled_pat_if pat_bus ();

    logic ready_q;
    logic fault_q;
    logic [31:0] rdata_q;
    logic wait_q;
    logic irq_q;
    logic [31:0] ctrl_q;
    logic [`SLED_EV_W-1:0] ev_stat_q;
    logic [`SLED_EV_W-1:0] ev_mask_q;
    logic [`SLED_EV_W-1:0] ev_prev_q;
    logic pdm_qual;
    sled_pat_t ready_sel;
    sled_pat_t fault_sel;

    // Waveform generator runs free; lamps just pick a phase of it
    sled_pattern #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_pattern (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pat(pat_bus.src)
    );

    // Remote short is seen through the sensor bus, so it is qualified
    sled_qual u_pdm_qual (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .tick_ms(pat_bus.tick_ms),
        .delay_ms(ctrl_q[`SLED_CTRL_DLY_MSB:`SLED_CTRL_DLY_LSB]),
        .raw(power_distribution_module_short),
        .qual(pdm_qual)
    );

    // Control fields
    wire ctl_en = ctrl_q[`SLED_CTRL_EN_BIT];
    wire ctl_test = ctrl_q[`SLED_CTRL_TEST_BIT];

    // Condition decode
    wire dead = !logic_pwr_ok || mod_failed;
    // Local field loss bypasses the qualifier
    wire field_fault = field_pwr_lost || pdm_qual;

    // Maps a pattern choice onto the free running waveforms
    function automatic logic pat_level(input sled_pat_t sel, input logic flk,
                                       input logic bl1, input logic bl2);
        logic lvl;
        lvl = 1'b0;
        case (sel)
            SLED_PAT_OFF: lvl = 1'b0;
            SLED_PAT_ON: lvl = 1'b1;
            SLED_PAT_FLICK: lvl = flk;
            SLED_PAT_BLINK1: lvl = bl1;
            SLED_PAT_BLINK2: lvl = bl2;
            default: lvl = 1'b0;
        endcase
        return lvl;
    endfunction

    // Ready lamp choice, most fundamental condition first
    always_comb begin
        if (dead) begin
            ready_sel = SLED_PAT_OFF;
        end else if (wdog_timeout) begin
            ready_sel = SLED_PAT_ON;
        end else if (auto_addr) begin
            ready_sel = SLED_PAT_FLICK;
        end else if (pre_op) begin
            ready_sel = SLED_PAT_BLINK1;
        end else if (operational) begin
            ready_sel = SLED_PAT_ON;
        end else begin
            ready_sel = SLED_PAT_OFF;
        end
    end

    // Fault lamp choice; dark on a dead module, lit on watchdog timeout, else dark while addressing, otherwise the most severe active cause wins
    always_comb begin
        if (dead) begin
            fault_sel = SLED_PAT_OFF;
        end else if (wdog_timeout) begin
            fault_sel = SLED_PAT_ON;
        end else if (auto_addr) begin
            fault_sel = SLED_PAT_OFF;
        end else if (island_bus_stopped) begin
            fault_sel = SLED_PAT_BLINK2;
        end else if (field_fault) begin
            fault_sel = SLED_PAT_FLICK;
        end else if (nonfatal_err) begin
            fault_sel = SLED_PAT_BLINK1;
        end else begin
            fault_sel = SLED_PAT_OFF;
        end
    end

    // Selection is combinational, so a pattern ends the cycle its cause drops
    wire ready_d = ctl_test ||
        (ctl_en && pat_level(ready_sel, pat_bus.flick, pat_bus.blink1, pat_bus.blink2));
    wire fault_d = ctl_test ||
        (ctl_en && pat_level(fault_sel, pat_bus.flick, pat_bus.blink1, pat_bus.blink2));

    // Lamp drivers are registered to keep them glitch free
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
            fault_q <= fault_d;
        end
    end

    // Events are the rising edges of the fault causes
    wire [`SLED_EV_W-1:0] ev_now = {dead, nonfatal_err, field_fault, island_bus_stopped,
                                    wdog_timeout};
    wire [`SLED_EV_W-1:0] ev_rise = ev_now & ~ev_prev_q;

    // Bus decode; a read is captured while waitrequest is still high, a write lands once it is low
    wire acc = (avs_read || avs_write) && wait_q;
    wire wr_acc = avs_write && !wait_q;
    wire rd_go = avs_read && wait_q;
    wire sel_ctrl = (avs_address == `SLED_REG_CTRL);
    wire sel_stat = (avs_address == `SLED_REG_STAT);
    wire sel_istat = (avs_address == `SLED_REG_IRQ_STAT);
    wire sel_imask = (avs_address == `SLED_REG_IRQ_MASK);
    wire sel_cond = (avs_address == `SLED_REG_COND);
    wire istat_rd = avs_read && !wait_q && sel_istat;

    // Live status word: lamps and selected patterns
    wire [31:0] stat_word = {22'h0, fault_sel, ready_sel, 2'h0, fault_q, ready_q};
    wire [31:0] cond_word = {21'h0, pdm_qual, island_bus_stopped, nonfatal_err,
                             power_distribution_module_short, field_pwr_lost, pre_op,
                             operational, wdog_timeout, auto_addr, mod_failed,
                             logic_pwr_ok};

    // Read mux; unmapped offsets read as zero
    wire [31:0] rd_mux = sel_ctrl ? ctrl_q :
                         sel_stat ? stat_word :
                         sel_istat ? {27'h0, ev_stat_q} :
                         sel_imask ? {27'h0, ev_mask_q} :
                         sel_cond ? cond_word : 32'h0;

    // Waitrequest drops for one cycle, one cycle after the request appears
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= !acc;
            if (rd_go) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Control and mask registers; writes land on the accepting edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `SLED_CTRL_RESET;
            ev_mask_q <= '0;
        end else if (wr_acc) begin
            if (sel_ctrl) begin
                ctrl_q <= {24'h0, avs_writedata[7:4], 2'h0, avs_writedata[1:0]};
            end
            if (sel_imask) begin
                ev_mask_q <= avs_writedata[`SLED_EV_W-1:0];
            end
        end
    end

    // Sticky events, cleared by reading; a new event beats the clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_prev_q <= '0;
            ev_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ev_prev_q <= ev_now;
            ev_stat_q <= (istat_rd ? '0 : ev_stat_q) | ev_rise;
            irq_q <= |(((istat_rd ? '0 : ev_stat_q) | ev_rise) & ev_mask_q);
        end
    end

    assign ready_led = ready_q;
    assign fault_led = fault_q;
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq = irq_q;
endmodule

// ===== sled_lamp_mon.sv
// Lamp observer: measures lit and dark run lengths of one front panel lamp
`timescale 1ns/100ps
module sled_lamp_mon (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Lamp and clear
    input wire logic lamp,
    input wire logic clr,
    // Measured runs
    output logic [15:0] on_len,
    output logic [15:0] off_max
);
    logic lamp_q;
    logic [15:0] run_q;
    logic arm_q;
    // A run is recorded only when it ends, so a lamp stuck at one level reports nothing
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lamp_q <= 1'b0;
            run_q <= 16'h0001;
            arm_q <= 1'b0;
            on_len <= 16'h0000;
            off_max <= 16'h0000;
        end else begin
            lamp_q <= lamp;
            run_q <= (lamp != lamp_q) ? 16'h0001 : run_q + 16'h0001;
            // A run that began before the clear is partial, so only runs started after it count
            if (clr) begin
                arm_q <= 1'b0;
                on_len <= 16'h0000;
                off_max <= 16'h0000;
            end else if (lamp != lamp_q && !arm_q) begin
                arm_q <= 1'b1;
            end else if (lamp != lamp_q && lamp_q) begin
                on_len <= run_q;
            end else if (lamp != lamp_q && run_q > off_max) begin
                off_max <= run_q; // Longest dark run shows the double blink gap
            end
        end
    end
endmodule

// ===== sled_top_props.sv
// Checker of lamp priorities and bus handshake timing at the sequencer ports
`timescale 1ns/100ps
module sled_top_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Conditions
    input wire logic logic_pwr_ok,
    input wire logic mod_failed,
    input wire logic auto_addr,
    input wire logic wdog_timeout,
    input wire logic operational,
    input wire logic pre_op,
    input wire logic field_pwr_lost,
    input wire logic power_distribution_module_short,
    input wire logic nonfatal_err,
    input wire logic island_bus_stopped,
    // Lamps and bus
    input wire logic ready_led,
    input wire logic fault_led,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Powered, healthy and not timed out
    sequence s_live;
        logic_pwr_ok && !mod_failed && !wdog_timeout;
    endsequence
    // No fault cause; the raw short counts since the qualifier drops at once
    sequence s_calm;
        s_live ##0 !auto_addr && !island_bus_stopped && !field_pwr_lost
            && !power_distribution_module_short && !nonfatal_err;
    endsequence
    a_dead_lamps_dark: assert property (!logic_pwr_ok || mod_failed |=> !ready_led && !fault_led)
        else $error("lamps lit on a dead module");
    a_wdog_both_lit: assert property (logic_pwr_ok && !mod_failed && wdog_timeout |=> ready_led && fault_led)
        else $error("watchdog lamps not both lit");
    a_auto_fault_dark: assert property (s_live ##0 auto_addr |=> !fault_led)
        else $error("fault lamp lit while addressing");
    a_oper_ready_lit: assert property (s_live ##0 !auto_addr && !pre_op && operational |=> ready_led)
        else $error("ready lamp dark while operational");
    a_idle_ready_dark: assert property (s_live ##0 !auto_addr && !pre_op && !operational |=> !ready_led)
        else $error("ready lamp lit with no cause");
    a_calm_fault_dark: assert property (s_calm |=> !fault_led)
        else $error("fault lamp lit with no cause");
    a_bus_answer_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");
    a_idle_wait_high: assert property (!(avs_read || avs_write) [*2] |-> avs_waitrequest)
        else $error("waitrequest low on an idle bus");
endmodule
bind sled_top sled_top_props i_props (.sys_clk, .rst_b, .logic_pwr_ok, .mod_failed, .auto_addr,
    .wdog_timeout, .operational, .pre_op, .field_pwr_lost, .power_distribution_module_short,
    .nonfatal_err, .island_bus_stopped, .ready_led, .fault_led, .avs_read, .avs_write,
    .avs_waitrequest);

// ===== sled_top_tb.sv
// Self-checking bench for the sequencer: lamp patterns, priorities, registers and interrupt
`timescale 1ns/100ps
`include "sled_params.svh"
module sled_top_tb;
    import sled_pkg::*;
    localparam int CYC = 10;
    localparam int FLK = 50 * CYC;
    localparam int BLK = 200 * CYC;
    localparam int GAP = 1000 * CYC;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [9:0] c_q = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ready_led;
    logic fault_led;
    logic irq;
    logic clr = 1'b0;
    logic [15:0] r_on;
    logic [15:0] r_off;
    logic [15:0] f_on;
    logic [15:0] f_off;
    logic [31:0] q;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0;
    sled_top #(.CYC_PER_MS(CYC)) i_dut (.sys_clk, .rst_b, .logic_pwr_ok(c_q[0]),
        .mod_failed(c_q[1]), .auto_addr(c_q[2]), .wdog_timeout(c_q[3]), .operational(c_q[4]),
        .pre_op(c_q[5]), .field_pwr_lost(c_q[6]), .power_distribution_module_short(c_q[7]),
        .nonfatal_err(c_q[8]), .island_bus_stopped(c_q[9]), .ready_led, .fault_led,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
    sled_lamp_mon i_rmon (.sys_clk, .rst_b, .lamp(ready_led), .clr, .on_len(r_on), .off_max(r_off));
    sled_lamp_mon i_fmon (.sys_clk, .rst_b, .lamp(fault_led), .clr, .on_len(f_on), .off_max(f_off));
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard, well above the roughly 50000 cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One Avalon access; the request stands until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Apply conditions, wait three cycles for the lamps to follow, clear the observers, then watch n cycles
    task automatic run(input logic [9:0] c, input int n);
        @(posedge sys_clk);
        c_q <= c;
        repeat (3) @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        bus(1'b0, 3'h0, 32'h0);
        check("ctrl", q, `SLED_CTRL_RESET);
        bus(1'b1, 3'h5, 32'hffff_ffff);
        bus(1'b0, 3'h5, 32'h0);
        check("unmapped", q, 32'h0);
        run(10'h3fe, 20);
        check("dead", {30'h0, ready_led, fault_led}, 32'h0);
        run(10'h005, 4 * FLK);
        check("rdy flick on", {16'h0, r_on}, 32'(FLK));
        check("rdy flick off", {16'h0, r_off}, 32'(FLK));
        run(10'h121, 4 * BLK);
        check("rdy blink on", {16'h0, r_on}, 32'(BLK));
        check("rdy blink off", {16'h0, r_off}, 32'(BLK));
        check("flt blink on", {16'h0, f_on}, 32'(BLK));
        check("flt blink off", {16'h0, f_off}, 32'(BLK));
        // Bus stopped must outrank the field fault and the nonfatal error
        run(10'h361, 2 * (3 * BLK + GAP) + BLK);
        bus(1'b0, 3'h4, 32'h0);
        check("cond", q, 32'h0000_0361);
        check("dbl on", {16'h0, f_on}, 32'(BLK));
        check("dbl gap", {16'h0, f_off}, 32'(GAP));
        // Local field loss shows without the short qualifying delay
        run(10'h041, 0);
        bus(1'b0, 3'h1, 32'h0);
        check("field pat", 32'(q[9:7]), 32'(SLED_PAT_FLICK));
        repeat (4 * FLK) @(posedge sys_clk);
        check("flt flick on", {16'h0, f_on}, 32'(FLK));
        check("flt flick off", {16'h0, f_off}, 32'(FLK));
        run(10'h001, 4);
        bus(1'b0, 3'h1, 32'h0);
        check("clear pat", 32'(q[9:7]), 32'(SLED_PAT_OFF));
        run(10'h081, 0);
        t0 = cyc;
        q = 32'h0;
        while (q[9:7] !== 3'(SLED_PAT_FLICK) && cyc - t0 < 15 * CYC + 10) begin
            bus(1'b0, 3'h1, 32'h0);
        end
        check("short pat", 32'(q[9:7]), 32'(SLED_PAT_FLICK));
        repeat (4 * FLK) @(posedge sys_clk);
        check("short flick", {16'h0, f_on}, 32'(FLK));
        run(10'h011, 4);
        bus(1'b0, 3'h1, 32'h0);
        check("oper pat", 32'(q[6:4]), 32'(SLED_PAT_ON));
        // Interrupt: clear, unmask watchdog only, raise it, read clears
        bus(1'b0, 3'h2, 32'h0);
        bus(1'b1, 3'h3, 32'h0000_0001);
        bus(1'b0, 3'h3, 32'h0);
        check("mask", q, 32'h0000_0001);
        run(10'h009, 4);
        check("irq set", {31'h0, irq}, 32'h1);
        bus(1'b0, 3'h2, 32'h0);
        check("wdog ev", {31'h0, q[0]}, 32'h1);
        repeat (3) @(posedge sys_clk);
        check("irq clr", {31'h0, irq}, 32'h0);
        run(10'h101, 4);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b0, 3'h2, 32'h0);
        check("nonfatal ev", {31'h0, q[3]}, 32'h1);
        give_verdict();
    end
endmodule
